// ### common/flash_ctrl_pkg.sv
package flash_ctrl_pkg;
   // ------------------------------------------------------------
   // Instruction codes
   // ------------------------------------------------------------
   localparam logic [7:0] RESET_ARM_CMD = 8'h66;
   localparam logic [7:0] RESET_CMD = 8'h99;
   localparam logic [7:0] ENTER_FOUR_LINE_CMD = 8'h38;
   localparam logic [7:0] EXIT_FOUR_LINE_CMD = 8'hFF;
   localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
   localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] DEEP_SLEEP_CMD = 8'hB9;
   localparam logic [7:0] WAKE_AND_ID_CMD = 8'hAB;
   localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
   localparam logic [7:0] QUAD_PAGE_PROGRAM_CMD = 8'h32;
   localparam logic [7:0] SECTOR_ERASE_CMD = 8'h20;
   localparam logic [7:0] HALF_BLOCK_ERASE_CMD = 8'h52;
   localparam logic [7:0] BLOCK_ERASE_CMD = 8'hD8;
   localparam logic [7:0] CHIP_ERASE_CMD = 8'hC7;
   // ------------------------------------------------------------
   // Status byte layout and reset values
   // ------------------------------------------------------------
   localparam int WIP_POS = 0;
   localparam int WEL_POS = 1;
   localparam int CODE_LSB = 2;
   localparam int BOOT_LOCK_POS = 6;
   localparam int STATUS_LOCK_POS = 7;
   localparam int OTP_TB_POS = 0;
   localparam int OTP_SECTOR_POS = 1;
   localparam logic [3:0] CODE_RESET = 4'h0;
   // ------------------------------------------------------------
   // Array geometry and lengths
   // ------------------------------------------------------------
   localparam int ADDR_W = 23;
   localparam int PAGE_BYTES = 256;
   localparam logic [7:0] BLOCK_COUNT = 8'h80;
   localparam logic [6:0] TOP_BLOCK = 7'h7F;
   localparam logic [3:0] TOP_SECTOR = 4'hF;
   localparam logic [2:0] LEN_ONE = 3'h1;
   localparam logic [2:0] LEN_STATUS = 3'h2;
   localparam logic [2:0] LEN_OTP = 3'h3;
   localparam logic [2:0] LEN_ERASE = 3'h4;
   localparam logic [2:0] LEN_PROGRAM = 3'h5;
   localparam logic [2:0] LEN_MAX = 3'h7;
   localparam logic [7:0] ERASE_FILL_VALUE = 8'hFF;
   // ------------------------------------------------------------
   // Internal cycle kinds, power states, sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      KIND_NONE = 3'b000, KIND_STATUS = 3'b001, KIND_PROGRAM = 3'b010, KIND_SECTOR = 3'b011,
      KIND_HALF_BLOCK = 3'b100, KIND_BLOCK = 3'b101, KIND_CHIP = 3'b110
   } cycle_kind_t;
   typedef enum logic [1:0] {
      PWR_STANDBY = 2'b00, PWR_ACTIVE = 2'b01, PWR_DEEP = 2'b10
   } power_t;
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00, SEQ_STREAM = 2'b01, SEQ_WAIT = 2'b10
   } seq_t;
endpackage : flash_ctrl_pkg

// ### common/shift_if.sv
`timescale 1ns/10ps
interface shift_if;
   logic frame_start;
   logic frame_end;
   logic selected;
   logic byte_valid;
   logic [7:0] byte_data;
   logic aligned;
   logic wp_level;
   logic wide;
   modport shifter (output frame_start, frame_end, selected, byte_valid, byte_data, aligned, wp_level,
                    input wide);
   modport decoder (input frame_start, frame_end, selected, byte_valid, byte_data, aligned, wp_level,
                    output wide);
endinterface : shift_if

// ### src/spi_shifter.sv
`timescale 1ns/10ps
module spi_shifter
   import flash_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Pins
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic [3:0] DQ_IN,
   // Decoder side
   shift_if.shifter lnk
);
   logic sclk_m_q, sclk_s_q, sclk_p_q;
   logic cs_n_m_q, cs_n_s_q, cs_n_p_q;
   logic [3:0] dq_m_q, dq_s_q;
   logic [7:0] shift_q;
   logic [2:0] bit_cnt_q;
   logic rise;
   logic [2:0] bit_next;
   logic [7:0] shift_next;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         sclk_m_q <= 1'b0;
         sclk_s_q <= 1'b0;
         sclk_p_q <= 1'b0;
         cs_n_m_q <= 1'b1;
         cs_n_s_q <= 1'b1;
         cs_n_p_q <= 1'b1;
         dq_m_q <= 4'hF;
         dq_s_q <= 4'hF;
      end else begin
         sclk_m_q <= SCLK;
         sclk_s_q <= sclk_m_q;
         sclk_p_q <= sclk_s_q;
         cs_n_m_q <= CS_N;
         cs_n_s_q <= cs_n_m_q;
         cs_n_p_q <= cs_n_s_q;
         dq_m_q <= DQ_IN;
         dq_s_q <= dq_m_q;
      end
   end

   // ------------------------------------------------------------
   // Bit shifting, one or four lanes per rising edge
   // ------------------------------------------------------------
   assign rise = sclk_s_q & ~sclk_p_q & ~cs_n_s_q;
   assign bit_next = lnk.wide ? bit_cnt_q + 3'h4 : bit_cnt_q + 3'h1;
   assign shift_next = lnk.wide ? {shift_q[3:0], dq_s_q} : {shift_q[6:0], dq_s_q[0]};

   always_ff @(posedge CLK) begin
      if (RST) begin
         shift_q <= 8'h00;
         bit_cnt_q <= 3'h0;
         lnk.byte_valid <= 1'b0;
         lnk.byte_data <= 8'h00;
      end else begin
         lnk.byte_valid <= 1'b0;
         if (cs_n_p_q & ~cs_n_s_q) begin
            bit_cnt_q <= 3'h0;
         end else if (rise) begin
            shift_q <= shift_next;
            bit_cnt_q <= bit_next;
            if (bit_next == 3'h0) begin
               lnk.byte_valid <= 1'b1;
               lnk.byte_data <= shift_next;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Frame events
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         lnk.frame_start <= 1'b0;
         lnk.frame_end <= 1'b0;
         lnk.selected <= 1'b0;
         lnk.wp_level <= 1'b1;
      end else begin
         lnk.frame_start <= cs_n_p_q & ~cs_n_s_q;
         lnk.frame_end <= ~cs_n_p_q & cs_n_s_q;
         lnk.selected <= ~cs_n_s_q;
         lnk.wp_level <= dq_s_q[2];
      end
   end

   assign lnk.aligned = (bit_cnt_q == 3'h0);
endmodule : spi_shifter

// ### src/flash_write_protect.sv
`timescale 1ns/10ps
// Operation
// - Code 38h switches to four-line data mode
// - Up to 256 bytes, wrapping inside one page
// - Program only clears bits; erase gives FFh
// - Sector, half block, block and chip erase
// - Busy flag set during internal cycles
// - Deep while asleep, else active while selected or busy, else standby
// - Deep sleep ignores all but wake command
// - Write commands need whole-byte clock count
// - Modifying commands need write enable latch
// - Latch cleared by writes, erases, resets
// - Protect code selects read-only array part
// - Write-protect pin freezes protect code and status lock bit outside four-line mode
// - Boot lock bit locks edge block/sector
// - Top/bottom and block/sector bits set once
// - Most significant bit first, rising edges
// - Reset needs reset arm command just before
// - FFh leaves four-line mode
module flash_write_protect
   import flash_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Serial pins
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic [3:0] DQ_IN,
   output logic [3:0] DQ_OUT,
   output logic [3:0] DQ_OE_N,
   // Array engine
   input wire logic ARRAY_DONE,
   output logic CYCLE_START,
   output logic [2:0] CYCLE_KIND,
   output logic [ADDR_W-1:0] CYCLE_ADDR,
   output logic PROG_WE,
   output logic [ADDR_W-1:0] PROG_ADDR,
   output logic [7:0] PROG_CLEAR,
   output logic [7:0] ERASE_FILL,
   // Status
   output logic [7:0] STATUS,
   output logic BOOT_TB,
   output logic BOOT_SECTOR,
   output logic FOUR_LINE_MODE,
   output logic SOFTWARE_PROTECT_MODE,
   output logic HARDWARE_PROTECT_MODE,
   output logic [1:0] POWER_STATE
);
   shift_if lnk ();

   logic [7:0] page_buf [0:PAGE_BYTES-1];
   logic [7:0] cmd_q;
   logic [2:0] len_q;
   logic [23:0] addr_q;
   logic [7:0] arg1_q, arg2_q;
   logic [7:0] wr_ptr_q, rd_ptr_q;
   logic [8:0] data_cnt_q, remain_q;
   logic write_enable_latch_q, four_line_mode_q, sleep_q, arm_q, qpp_wide_q;
   logic status_lock_bit_q, boot_lock_enable_q;
   logic [3:0] code_q;
   logic boot_tb_q, boot_sector_q, tb_done_q, sector_done_q;
   seq_t seq_q;
   logic busy, hw_protect, is_program, is_erase, go, target_locked;
   cycle_kind_t erase_kind;

   spi_shifter u_shifter (
      .CLK(CLK),
      .RST(RST),
      .SCLK(SCLK),
      .CS_N(CS_N),
      .DQ_IN(DQ_IN),
      .lnk(lnk)
   );

   // ------------------------------------------------------------
   // Protection helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] protect_blocks(input logic [3:0] code);
      case (code)
         4'h0: protect_blocks = 8'h00;
         4'h8: protect_blocks = 8'h60;
         4'h9: protect_blocks = 8'h70;
         4'hA: protect_blocks = 8'h78;
         4'hB: protect_blocks = 8'h7C;
         4'hC: protect_blocks = 8'h7E;
         4'hD: protect_blocks = 8'h7F;
         4'hE, 4'hF: protect_blocks = BLOCK_COUNT;
         default: protect_blocks = 8'h01 << (code - 4'h1);
      endcase
   endfunction : protect_blocks

   function automatic logic block_protected(input logic [6:0] blk, input logic [3:0] code, input logic tb);
      logic [7:0] n;
      n = protect_blocks(code);
      if (tb) begin
         block_protected = {1'b0, blk} < n;
      end else begin
         block_protected = {1'b0, blk} >= (BLOCK_COUNT - n);
      end
   endfunction : block_protected

   function automatic logic boot_hit(input logic [ADDR_W-1:0] a, input logic whole_block, input logic en,
                                     input logic tb, input logic sector);
      logic [6:0] edge_blk;
      logic [3:0] edge_sec;
      edge_blk = tb ? 7'h00 : TOP_BLOCK;
      edge_sec = tb ? 4'h0 : TOP_SECTOR;
      boot_hit = en & (a[22:16] == edge_blk) & (~sector | whole_block | (a[15:12] == edge_sec));
   endfunction : boot_hit

   // ------------------------------------------------------------
   // Command classification
   // ------------------------------------------------------------
   assign busy = (seq_q != SEQ_IDLE);
   assign hw_protect = ~lnk.wp_level & ~four_line_mode_q;
   assign is_program = (cmd_q == PAGE_PROGRAM_CMD) | (cmd_q == QUAD_PAGE_PROGRAM_CMD);
   assign is_erase = (cmd_q == SECTOR_ERASE_CMD) | (cmd_q == HALF_BLOCK_ERASE_CMD) |
                     (cmd_q == BLOCK_ERASE_CMD) | (cmd_q == CHIP_ERASE_CMD);
   assign go = lnk.frame_end & lnk.aligned & (len_q != 3'h0);
   assign lnk.wide = four_line_mode_q | qpp_wide_q;

   always_comb begin
      erase_kind = KIND_SECTOR;
      target_locked = 1'b0;
      case (cmd_q)
         HALF_BLOCK_ERASE_CMD: erase_kind = KIND_HALF_BLOCK;
         BLOCK_ERASE_CMD: erase_kind = KIND_BLOCK;
         CHIP_ERASE_CMD: erase_kind = KIND_CHIP;
         default: erase_kind = KIND_SECTOR;
      endcase
      if (cmd_q == CHIP_ERASE_CMD) begin
         target_locked = (code_q != CODE_RESET) | boot_lock_enable_q;
      end else begin
         target_locked = block_protected(addr_q[22:16], code_q, boot_tb_q) |
                         boot_hit(addr_q[22:0], erase_kind != KIND_SECTOR && !is_program,
                                  boot_lock_enable_q, boot_tb_q, boot_sector_q);
      end
   end

   // ------------------------------------------------------------
   // Frame collection
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         cmd_q <= 8'h00;
         len_q <= 3'h0;
         addr_q <= 24'h000000;
         arg1_q <= 8'h00;
         arg2_q <= 8'h00;
         wr_ptr_q <= 8'h00;
         data_cnt_q <= 9'h000;
         qpp_wide_q <= 1'b0;
      end else if (lnk.frame_start) begin
         len_q <= 3'h0;
         data_cnt_q <= 9'h000;
         qpp_wide_q <= 1'b0;
      end else if (lnk.frame_end) begin
         qpp_wide_q <= 1'b0;
      end else if (lnk.byte_valid) begin
         if (len_q != LEN_MAX) begin
            len_q <= len_q + 3'h1;
         end
         case (len_q)
            3'h0: cmd_q <= lnk.byte_data;
            3'h1: begin
               addr_q[23:16] <= lnk.byte_data;
               arg1_q <= lnk.byte_data;
            end
            3'h2: begin
               addr_q[15:8] <= lnk.byte_data;
               arg2_q <= lnk.byte_data;
            end
            3'h3: begin
               addr_q[7:0] <= lnk.byte_data;
               wr_ptr_q <= lnk.byte_data;
               qpp_wide_q <= (cmd_q == QUAD_PAGE_PROGRAM_CMD);
            end
            default: begin
               wr_ptr_q <= wr_ptr_q + 8'h01;
               if (data_cnt_q != 9'(PAGE_BYTES)) begin
                  data_cnt_q <= data_cnt_q + 9'h001;
               end
            end
         endcase
      end
   end

   // Page buffer; later bytes overwrite earlier ones after a page wrap
   always_ff @(posedge CLK) begin
      if (lnk.byte_valid && len_q >= LEN_ERASE && is_program && !busy) begin
         page_buf[wr_ptr_q] <= lnk.byte_data;
      end
   end

   // ------------------------------------------------------------
   // Mode, latch and status bits
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         write_enable_latch_q <= 1'b0;
         four_line_mode_q <= 1'b0;
         sleep_q <= 1'b0;
         arm_q <= 1'b0;
         status_lock_bit_q <= 1'b0;
         boot_lock_enable_q <= 1'b0;
         code_q <= CODE_RESET;
         boot_tb_q <= 1'b0;
         boot_sector_q <= 1'b0;
         tb_done_q <= 1'b0;
         sector_done_q <= 1'b0;
      end else if (go && sleep_q) begin
         if (cmd_q == WAKE_AND_ID_CMD) begin
            sleep_q <= 1'b0;
         end
      end else if (go) begin
         arm_q <= (cmd_q == RESET_ARM_CMD) && (len_q == LEN_ONE);
         case (cmd_q)
            ENTER_FOUR_LINE_CMD: four_line_mode_q <= 1'b1;
            EXIT_FOUR_LINE_CMD: four_line_mode_q <= 1'b0;
            WRITE_ENABLE_CMD: write_enable_latch_q <= !busy;
            WRITE_DISABLE_CMD: write_enable_latch_q <= busy & write_enable_latch_q;
            DEEP_SLEEP_CMD: sleep_q <= !busy && len_q == LEN_ONE;
            RESET_CMD: begin
               if (arm_q && !busy) begin
                  write_enable_latch_q <= 1'b0;
                  four_line_mode_q <= 1'b0;
               end
            end
            STATUS_WRITE_CMD: begin
               if (!busy && write_enable_latch_q && len_q >= LEN_STATUS) begin
                  write_enable_latch_q <= 1'b0;
                  boot_lock_enable_q <= arg1_q[BOOT_LOCK_POS];
                  if (!hw_protect) begin
                     status_lock_bit_q <= arg1_q[STATUS_LOCK_POS];
                     code_q <= arg1_q[CODE_LSB +: 4];
                  end
                  if (len_q >= LEN_OTP && !tb_done_q) begin
                     boot_tb_q <= arg2_q[OTP_TB_POS];
                     tb_done_q <= 1'b1;
                  end
                  if (len_q >= LEN_OTP && !sector_done_q) begin
                     boot_sector_q <= arg2_q[OTP_SECTOR_POS];
                     sector_done_q <= 1'b1;
                  end
               end
            end
            default: begin
               if ((is_program || is_erase) && !busy && write_enable_latch_q && !target_locked) begin
                  if ((is_program && len_q >= LEN_PROGRAM) || (is_erase && cmd_q == CHIP_ERASE_CMD) ||
                      (is_erase && len_q == LEN_ERASE)) begin
                     write_enable_latch_q <= 1'b0;
                  end
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Internal cycle sequencer
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         seq_q <= SEQ_IDLE;
         rd_ptr_q <= 8'h00;
         remain_q <= 9'h000;
         CYCLE_START <= 1'b0;
         CYCLE_KIND <= KIND_NONE;
         CYCLE_ADDR <= '0;
         PROG_WE <= 1'b0;
         PROG_ADDR <= '0;
         PROG_CLEAR <= 8'h00;
      end else begin
         CYCLE_START <= 1'b0;
         PROG_WE <= 1'b0;
         case (seq_q)
            SEQ_IDLE: begin
               if (go && !sleep_q && write_enable_latch_q) begin
                  if (cmd_q == STATUS_WRITE_CMD && len_q >= LEN_STATUS) begin
                     seq_q <= SEQ_WAIT;
                     CYCLE_START <= 1'b1;
                     CYCLE_KIND <= KIND_STATUS;
                  end else if (is_program && len_q >= LEN_PROGRAM && !target_locked) begin
                     seq_q <= SEQ_STREAM;
                     CYCLE_START <= 1'b1;
                     CYCLE_KIND <= KIND_PROGRAM;
                     CYCLE_ADDR <= addr_q[22:0];
                     remain_q <= data_cnt_q;
                     rd_ptr_q <= (data_cnt_q == 9'(PAGE_BYTES)) ? wr_ptr_q : addr_q[7:0];
                  end else if (is_erase && !target_locked &&
                               (cmd_q == CHIP_ERASE_CMD ? len_q == LEN_ONE : len_q == LEN_ERASE)) begin
                     seq_q <= SEQ_WAIT;
                     CYCLE_START <= 1'b1;
                     CYCLE_KIND <= erase_kind;
                     CYCLE_ADDR <= addr_q[22:0];
                  end
               end
            end
            SEQ_STREAM: begin
               PROG_WE <= 1'b1;
               PROG_ADDR <= {addr_q[22:8], rd_ptr_q};
               PROG_CLEAR <= ~page_buf[rd_ptr_q];
               rd_ptr_q <= rd_ptr_q + 8'h01;
               remain_q <= remain_q - 9'h001;
               if (remain_q == 9'h001) begin
                  seq_q <= SEQ_WAIT;
               end
            end
            SEQ_WAIT: begin
               if (ARRAY_DONE) begin
                  seq_q <= SEQ_IDLE;
                  CYCLE_KIND <= KIND_NONE;
               end
            end
            default: seq_q <= SEQ_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registered status outputs
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         STATUS <= 8'h00;
         BOOT_TB <= 1'b0;
         BOOT_SECTOR <= 1'b0;
         FOUR_LINE_MODE <= 1'b0;
         SOFTWARE_PROTECT_MODE <= 1'b0;
         HARDWARE_PROTECT_MODE <= 1'b0;
         POWER_STATE <= PWR_STANDBY;
         ERASE_FILL <= ERASE_FILL_VALUE;
         DQ_OUT <= 4'h0;
         DQ_OE_N <= 4'hF;
      end else begin
         STATUS <= {status_lock_bit_q, boot_lock_enable_q, code_q, write_enable_latch_q, busy};
         BOOT_TB <= boot_tb_q;
         BOOT_SECTOR <= boot_sector_q;
         FOUR_LINE_MODE <= four_line_mode_q;
         SOFTWARE_PROTECT_MODE <= (code_q != CODE_RESET);
         HARDWARE_PROTECT_MODE <= hw_protect;
         ERASE_FILL <= ERASE_FILL_VALUE;
         DQ_OUT <= 4'h0;
         DQ_OE_N <= 4'hF;
         if (sleep_q) begin
            POWER_STATE <= PWR_DEEP;
         end else if (lnk.selected || busy) begin
            POWER_STATE <= PWR_ACTIVE;
         end else begin
            POWER_STATE <= PWR_STANDBY;
         end
      end
   end
endmodule : flash_write_protect

// ### verif/fwp_checker.sv
`timescale 1ns/10ps
module fwp_checker
   import flash_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Watched ports
   input wire logic CS_N,
   input wire logic CYCLE_START,
   input wire logic [2:0] CYCLE_KIND,
   input wire logic [ADDR_W-1:0] CYCLE_ADDR,
   input wire logic PROG_WE,
   input wire logic [ADDR_W-1:0] PROG_ADDR,
   input wire logic [7:0] STATUS,
   input wire logic HARDWARE_PROTECT_MODE,
   input wire logic [1:0] POWER_STATE
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RST);
   AST_START_WEL: assert property (CYCLE_START |-> STATUS[WEL_POS])
      else $error("cycle started without latch");
   AST_START_IDLE: assert property (CYCLE_START |-> $past(CYCLE_KIND) == 3'h0)
      else $error("cycle started while busy");
   AST_START_DESEL: assert property (CYCLE_START |-> CS_N)
      else $error("cycle started inside a frame");
   AST_WIP_SET: assert property (CYCLE_START |-> ##[1:3] STATUS[WIP_POS])
      else $error("busy flag not set");
   AST_WIP_HOLD: assert property (CYCLE_KIND != 3'h0 && $past(CYCLE_KIND) != 3'h0 |-> STATUS[WIP_POS])
      else $error("busy flag dropped");
   AST_WEL_CLR: assert property (CYCLE_START |-> ##[1:3] !STATUS[WEL_POS])
      else $error("latch not cleared");
   AST_ACTIVE: assert property (CYCLE_KIND != 3'h0 && $past(CYCLE_KIND) != 3'h0 |-> POWER_STATE == 2'h1)
      else $error("not active while busy");
   AST_PAGE: assert property (PROG_WE |-> CYCLE_KIND == 3'h2 && PROG_ADDR[ADDR_W-1:8] == CYCLE_ADDR[ADDR_W-1:8])
      else $error("byte write outside page");
   AST_HPM: assert property (HARDWARE_PROTECT_MODE && $past(HARDWARE_PROTECT_MODE) |=> $stable({STATUS[7], STATUS[5:2]}))
      else $error("protect bits changed");
endmodule : fwp_checker

// ### verif/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model (
   // Pins toward the device
   output logic SCLK,
   output logic CS_N,
   output logic [3:0] DQ
);
   // ------------------------------------------------------------
   // Frame driver
   // ------------------------------------------------------------
   logic quad = 1'b0;
   logic wp_n = 1'b1;
   logic [3:0] dq_q = 4'hA;
   assign DQ = quad ? dq_q : {dq_q[3], wp_n, dq_q[1:0]};
   initial begin
      SCLK = 1'b0;
      CS_N = 1'b1;
   end
   task automatic frame(input logic [63:0] d, input int nbits);
      int step;
      step = quad ? 4 : 1;
      CS_N = 1'b0;
      for (int i = 0; i < nbits; i += step) begin
         dq_q = quad ? d[63-i -: 4] : {1'b1, 1'b1, ~dq_q[1], d[63-i]};
         #24 SCLK = 1'b1;
         #24 SCLK = 1'b0;
      end
      #24 CS_N = 1'b1;
      dq_q = ~dq_q;
      #60;
   endtask : frame
endmodule : spi_host_model

// ### verif/tb_top.sv
`timescale 1ns/10ps
module tb_top
   import flash_ctrl_pkg::*;
;
   // ------------------------------------------------------------
   // Bench
   // ------------------------------------------------------------
   logic CLK, RST, SCLK, CS_N, ARRAY_DONE, CYCLE_START, PROG_WE, done_en;
   logic FOUR_LINE_MODE, SOFTWARE_PROTECT_MODE, HARDWARE_PROTECT_MODE, BOOT_TB, BOOT_SECTOR;
   logic [3:0] DQ_IN, DQ_OE_N;
   logic [2:0] CYCLE_KIND, kind_seen;
   logic [ADDR_W-1:0] CYCLE_ADDR, PROG_ADDR, addr_seen;
   logic [7:0] STATUS, PROG_CLEAR, ERASE_FILL, clear_seen;
   logic [7:0] codes [4] = '{8'h20, 8'h52, 8'hD8, 8'hC7};
   logic [1:0] POWER_STATE;
   int miscompares, cmp_count, starts, writes, s;
   spi_host_model i_host (.SCLK, .CS_N, .DQ(DQ_IN));
   flash_write_protect i_dut (.CLK, .RST, .SCLK, .CS_N, .DQ_IN, .DQ_OUT(), .DQ_OE_N, .ARRAY_DONE, .CYCLE_START,
      .CYCLE_KIND, .CYCLE_ADDR, .PROG_WE, .PROG_ADDR, .PROG_CLEAR, .ERASE_FILL, .STATUS, .BOOT_TB,
      .BOOT_SECTOR, .FOUR_LINE_MODE, .SOFTWARE_PROTECT_MODE, .HARDWARE_PROTECT_MODE, .POWER_STATE);
   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      ARRAY_DONE <= done_en && CYCLE_KIND != 3'h0;
      if (CYCLE_START) begin
         starts <= starts + 1;
         kind_seen <= CYCLE_KIND;
      end
      if (PROG_WE) begin
         writes <= writes + 1;
         addr_seen <= PROG_ADDR;
         clear_seen <= PROG_CLEAR;
      end
   end
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic send(input logic [63:0] d, input int nbits);
      @(posedge CLK);
      #1;
      i_host.frame(d << (64 - nbits), nbits);
      repeat (10) @(posedge CLK);
      #1;
   endtask : send
   task automatic idle;
      for (int i = 0; i < 400 && STATUS[WIP_POS] !== 1'b0; i++) @(posedge CLK);
      #1;
   endtask : idle
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   initial begin
      #300000;
      miscompares++;
      report_and_stop();
   end
   initial begin
      {RST, done_en, ARRAY_DONE, miscompares, cmp_count, starts, writes} = {2'b11, 1'b0, 128'h0};
      repeat (16) @(posedge CLK);
      #1 RST = 1'b0;
      repeat (8) @(posedge CLK);
      chk("status", 8'h00, STATUS);
      chk("fill", 8'hFF, ERASE_FILL);
      chk("power", 2'h0, POWER_STATE);
      chk("oe", 4'hF, DQ_OE_N);
      send(48'h020012FF5AC3, 48);
      chk("starts", 0, starts);
      send(8'h06, 8);
      chk("latch", 1, STATUS[WEL_POS]);
      send(48'h020012FF5AC3, 47);
      chk("starts", 0, starts);
      send(48'h020012FF5AC3, 48);
      idle();
      chk("kind", 2, kind_seen);
      chk("caddr", 24'h0012FF, CYCLE_ADDR);
      chk("addr", 24'h001200, addr_seen);
      chk("clear", 8'h3C, clear_seen);
      chk("writes", 2, writes);
      chk("status", 8'h00, STATUS);
      $display("test program done");
      for (int i = 0; i < 4; i++) begin
         send(8'h06, 8);
         send(i < 3 ? {codes[i], 24'h010000} : codes[i], i < 3 ? 32 : 8);
         idle();
         chk("kind", 3 + i, kind_seen);
      end
      done_en = 1'b0;
      send(8'h06, 8);
      send(32'h20020000, 32);
      chk("busy", 1, STATUS[WIP_POS]);
      chk("power", 2'h1, POWER_STATE);
      send(8'h06, 8);
      chk("latch", 0, STATUS[WEL_POS]);
      done_en = 1'b1;
      idle();
      chk("power", 2'h0, POWER_STATE);
      $display("test erase done");
      send(8'h06, 8);
      send(24'h010400, 24);
      idle();
      chk("code", 1, STATUS[5:2]);
      chk("spm", 1, SOFTWARE_PROTECT_MODE);
      chk("boot", 0, {BOOT_TB, BOOT_SECTOR});
      send(8'h06, 8);
      s = starts;
      send(32'h207F0000, 32);
      chk("starts", s, starts);
      send(32'h207E0000, 32);
      idle();
      chk("starts", s + 1, starts);
      i_host.wp_n = 1'b0;
      send(8'h06, 8);
      chk("hpm", 1, HARDWARE_PROTECT_MODE);
      send(24'h010000, 24);
      idle();
      chk("code", 1, STATUS[5:2]);
      i_host.wp_n = 1'b1;
      $display("test protect done");
      send(8'hB9, 8);
      chk("power", 2'h2, POWER_STATE);
      send(8'h06, 8);
      chk("latch", 0, STATUS[WEL_POS]);
      send(32'hAB000000, 32);
      chk("power", 2'h0, POWER_STATE);
      send(8'h06, 8);
      send(8'h66, 8);
      send(8'h99, 8);
      chk("latch", 0, STATUS[WEL_POS]);
      send(8'h06, 8);
      send(8'h66, 8);
      send(8'h06, 8);
      send(8'h99, 8);
      chk("latch", 1, STATUS[WEL_POS]);
      send(8'h38, 8);
      chk("four", 1, FOUR_LINE_MODE);
      i_host.quad = 1'b1;
      send(8'h04, 8);
      chk("latch", 0, STATUS[WEL_POS]);
      send(8'hFF, 8);
      chk("four", 0, FOUR_LINE_MODE);
      $display("test modes done");
      report_and_stop();
   end
endmodule : tb_top
bind flash_write_protect fwp_checker i_chk (.CLK, .RST, .CS_N, .CYCLE_START, .CYCLE_KIND, .CYCLE_ADDR, .PROG_WE,
   .PROG_ADDR, .STATUS, .HARDWARE_PROTECT_MODE, .POWER_STATE);
